// [bklt_defines.svh]
// Offsets, field positions, reset values and timing counts of the backlight register bank.
// Assumes a 125 MHz system clock; included by bare name where needed.
`ifndef BKLT_DEFINES_SVH
`define BKLT_DEFINES_SVH
`define BKLT_OFS_BRT 8'h00
`define BKLT_OFS_CTL 8'h01
`define BKLT_OFS_STAT 8'h02
`define BKLT_OFS_ID 8'h03
`define BKLT_CTL_EN 0
`define BKLT_CTL_SEL 1
`define BKLT_CTL_MD 2
`define BKLT_ST_FAULT 0
`define BKLT_ST_THRM 1
`define BKLT_ST_OVC 2
`define BKLT_ST_ON 3
`define BKLT_ST_ONE 4
`define BKLT_ST_MULTI 5
`define BKLT_ID_PANEL 7
`define BKLT_RST_BRT 8'hff
`define BKLT_RST_CTL 3'h0
`define BKLT_RST_STAT 8'h00
`define BKLT_CLK_NS 8
`define BKLT_ON_TIME_NS 4000000
`define BKLT_ON_DELAY_CYC (`BKLT_ON_TIME_NS / `BKLT_CLK_NS)
`define BKLT_DUTY_WIN 8'hfe
`endif

// [bklt_pkg.sv]
// Types shared by the backlight register bank and its helpers.
// Assumes the constants of bklt_defines.svh for offsets and counts.
package bklt_pkg;
   typedef enum logic [1:0] {
      MODE_SCALED = 2'b00,
      MODE_HOST = 2'b01,
      MODE_EXT = 2'b10
   } bklt_mode_t;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } bklt_reg_req_t;
   typedef struct packed {
      logic multi;
      logic single;
      logic overcurrent;
      logic thermal;
   } bklt_fault_t;
endpackage

// [bklt_on_timer.sv]
// Turn-on delay of the backlight: on rises a fixed count after enable, drops with it.
// Assumes the enable comes from logic on sys_clk.
`timescale 1ns/10ps
`include "bklt_defines.svh"
module bklt_on_timer #(
   parameter int unsigned DELAY_CYC = `BKLT_ON_DELAY_CYC
) (
   input wire logic sys_clk, // System clock.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic enable, // Requested backlight state.
   output logic lit // Backlight is on.
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt_ff;
   logic lit_ff;
   logic nxt_lit_ff;

   // Count while enabled; dropping enable clears at once so off is immediate.
   always_comb begin
      nxt_cnt_ff = 32'h0;
      nxt_lit_ff = 1'b0;
      if (enable) begin
         nxt_lit_ff = lit_ff || (cnt_ff >= DELAY_CYC - 32'h1);
         nxt_cnt_ff = nxt_lit_ff ? cnt_ff : cnt_ff + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= 32'h0;
         lit_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt_ff;
         lit_ff <= nxt_lit_ff;
      end
   end

   assign lit = lit_ff;
endmodule

// [bklt_duty_meter.sv]
// Measures the duty of the external dimming input on its own clock, hands words to sys_clk.
// Assumes dim_clk free-running and unrelated to sys_clk.
`timescale 1ns/10ps
`include "bklt_defines.svh"
module bklt_duty_meter (
   input wire logic sys_clk, // System clock.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic dim_clk, // Sampling clock of the external input.
   input wire logic ext_in, // External dimming input pin.
   output logic [7:0] duty // Last measured duty, 8'hff is fully high.
);
   logic [1:0] rst_sync_ff;
   logic [1:0] in_sync_ff;
   logic [7:0] win_ff, nxt_win_ff, hi_ff, nxt_hi_ff, word_ff, nxt_word_ff;
   logic tog_ff, nxt_tog_ff;
   logic [2:0] tog_sync_ff;
   logic [7:0] duty_ff, nxt_duty_ff;

   // Local reset release and input synchroniser on the sampling clock.
   always_ff @(posedge dim_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_sync_ff <= 2'h3;
         in_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b0};
         in_sync_ff <= {in_sync_ff[0], ext_in};
      end
   end

   // 255 samples per window so a steady high reads as 8'hff.
   always_comb begin
      nxt_win_ff = win_ff + 8'h1;
      nxt_hi_ff = hi_ff + {7'h0, in_sync_ff[1]};
      nxt_word_ff = word_ff;
      nxt_tog_ff = tog_ff;
      if (win_ff == `BKLT_DUTY_WIN) begin
         nxt_win_ff = 8'h0;
         nxt_hi_ff = 8'h0;
         nxt_word_ff = hi_ff + {7'h0, in_sync_ff[1]};
         nxt_tog_ff = ~tog_ff;
      end
   end

   always_ff @(posedge dim_clk or posedge sys_rst) begin
      if (sys_rst) begin
         win_ff <= 8'h0;
         hi_ff <= 8'h0;
         word_ff <= 8'h0;
         tog_ff <= 1'b0;
      end else if (rst_sync_ff[1]) begin
         win_ff <= 8'h0;
         hi_ff <= 8'h0;
         word_ff <= 8'h0;
         tog_ff <= 1'b0;
      end else begin
         win_ff <= nxt_win_ff;
         hi_ff <= nxt_hi_ff;
         word_ff <= nxt_word_ff;
         tog_ff <= nxt_tog_ff;
      end
   end

   // The word stays still for a whole window after the toggle, so it is safe to take.
   always_comb begin
      nxt_duty_ff = duty_ff;
      if (tog_sync_ff[2] != tog_sync_ff[1]) begin
         nxt_duty_ff = word_ff;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tog_sync_ff <= 3'h0;
         duty_ff <= 8'h0;
      end else begin
         tog_sync_ff <= {tog_sync_ff[1:0], tog_ff};
         duty_ff <= nxt_duty_ff;
      end
   end

   assign duty = duty_ff;
endmodule

// [bklt_ctrl_regs.sv]
// Control, status and identification registers of the LED backlight driver.
// Assumes a protocol engine on sys_clk presenting byte requests; fault pins are asynchronous.
// Summary of operation
// (R1) Select bit picks external, else host/scaled
// (R2) Scaled duty is brightness times measured duty
// (R3) Control bits 7 and 6 read zero
// (R4) Reserved control bits read zero, no effect
// (R5) Defined control bits read latched value
// (R6) Enable on lights backlight within 4 ms
// (R7) Enable off darkens backlight at once
// (R8) Brightness read: written value, external gives effective
// (R9) Entering host mode keeps output brightness
// (R10) Control resets to zero
// (R11) Summary bit ORs the four fault flags
// (R12) Status bit 3 shows backlight on
// (R13) Channel flags: one or more, two or more
// (R14) Summary sticky; cleared by enable toggle or write
// (R15) Only status bit 0 is writable
// (R16) Quick on then off records no fault
// (R17) Supply loss sets no fault flag
// (R18) Status resets to zero
// (R19) Identity: bit 7 one, vendor, revision
// (R20) Revision starts at zero
// (R21) Brightness writes only take in host modes
// (R22) Brightness resets to all ones
// (R23) Unmapped reads zero, writes ignored
`timescale 1ns/10ps
`include "bklt_defines.svh"
module bklt_ctrl_regs #(
   parameter int unsigned ON_DELAY_CYC = `BKLT_ON_DELAY_CYC,
   parameter int unsigned CHANNELS = 8,
   parameter logic [3:0] VENDOR_ID = 4'h5, // Arbitrary neutral value.
   parameter logic [2:0] REVISION = 3'h0
) (
   input wire logic sys_clk, // System clock, 125 MHz.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic dim_clk, // Sampling clock of the external dimming input.
   input wire bklt_pkg::bklt_reg_req_t reg_req, // Byte register request.
   output logic [7:0] reg_rdata, // Read data, one cycle after rd.
   output logic reg_rvalid, // Read data valid pulse.
   input wire logic external_dimming_input, // External dimming pin.
   input wire logic thermal_fault_pin, // Thermal shutdown sense.
   input wire logic overcurrent_pin, // Input overcurrent sense.
   input wire logic [CHANNELS-1:0] channel_fault_pin, // Per-channel shutdown sense.
   input wire logic backlight_supply_good, // Backlight supply rail present.
   output logic backlight_on, // Backlight lit.
   output logic [7:0] dim_duty // Effective dimming duty to the current sinks.
);
   logic [2:0] ctl_ff, nxt_ctl_ff;
   logic [7:0] brt_ff, nxt_brt_ff, out_ff, nxt_out_ff, duty_ff, nxt_duty_ff;
   logic fault_ff, nxt_fault_ff;
   logic [7:0] rdata_ff, nxt_rdata_ff;
   logic rvalid_ff, nxt_rvalid_ff;
   logic [CHANNELS+2:0] pin_s1_ff, pin_s2_ff;
   logic [7:0] meas;
   logic lit;
   logic wr_ctl, wr_brt, wr_stat, en_change, fault_clr, qual;
   bklt_pkg::bklt_mode_t cur_mode, new_mode;
   bklt_pkg::bklt_fault_t flags;
   logic [CHANNELS-1:0] ch_s;

   // Mode encoded by the select and interpretation bits.
   function automatic bklt_pkg::bklt_mode_t mode_of(input logic [2:0] c);
      if (c[`BKLT_CTL_SEL]) begin
         mode_of = bklt_pkg::MODE_EXT; // R1
      end else if (c[`BKLT_CTL_MD]) begin
         mode_of = bklt_pkg::MODE_HOST; // R1
      end else begin
         mode_of = bklt_pkg::MODE_SCALED; // R1
      end
   endfunction

   // Brightness times measured duty fraction, rounded, full scale 8'hff.
   function automatic logic [7:0] scale(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = (16'(a) * 16'(b) + 16'd127) / 16'd255;
      scale = p[7:0];
   endfunction

   bklt_duty_meter u_meter (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .dim_clk(dim_clk),
      .ext_in(external_dimming_input),
      .duty(meas)
   );

   // Enable feeds from its next value so a clearing write darkens on the same edge.
   bklt_on_timer #(.DELAY_CYC(ON_DELAY_CYC)) u_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .enable(nxt_ctl_ff[`BKLT_CTL_EN]), // R6 R7
      .lit(lit)
   );

   // Two-stage synchronisers for all analog sense pins.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
      end else begin
         pin_s1_ff <= {backlight_supply_good, overcurrent_pin, thermal_fault_pin,
                       channel_fault_pin};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // Faults only count while lit on a present rail, so quick toggles and rail loss stay quiet.
   always_comb begin
      qual = lit && pin_s2_ff[CHANNELS+2]; // R16 R17
      ch_s = pin_s2_ff[CHANNELS-1:0];
      flags.thermal = qual && pin_s2_ff[CHANNELS];
      flags.overcurrent = qual && pin_s2_ff[CHANNELS+1];
      flags.single = qual && (ch_s != '0); // R13
      flags.multi = qual && ((ch_s & (ch_s - 1'b1)) != '0); // R13
   end

   // Write decode; unmapped offsets match nothing.
   always_comb begin
      wr_ctl = reg_req.wr && (reg_req.addr == `BKLT_OFS_CTL);
      wr_brt = reg_req.wr && (reg_req.addr == `BKLT_OFS_BRT);
      wr_stat = reg_req.wr && (reg_req.addr == `BKLT_OFS_STAT); // R15
      cur_mode = mode_of(ctl_ff);
      new_mode = mode_of(reg_req.wdata[2:0]);
      en_change = wr_ctl && (reg_req.wdata[`BKLT_CTL_EN] != ctl_ff[`BKLT_CTL_EN]);
      fault_clr = en_change || (wr_stat && !reg_req.wdata[`BKLT_ST_FAULT]); // R14
   end

   // Control and brightness registers.
   always_comb begin
      nxt_ctl_ff = ctl_ff;
      nxt_brt_ff = brt_ff;
      if (wr_ctl) begin
         nxt_ctl_ff = reg_req.wdata[2:0]; // R4
      end
      if (wr_ctl && new_mode == bklt_pkg::MODE_HOST && cur_mode != bklt_pkg::MODE_HOST) begin
         nxt_brt_ff = out_ff; // R9
      end else if (wr_brt && cur_mode != bklt_pkg::MODE_EXT) begin
         nxt_brt_ff = reg_req.wdata; // R21
      end
   end

   // Output brightness follows the mode; external and scaled track the meter each cycle.
   always_comb begin
      unique case (cur_mode)
         bklt_pkg::MODE_EXT: nxt_out_ff = meas; // R1 R9
         bklt_pkg::MODE_SCALED: nxt_out_ff = scale(brt_ff, meas); // R2
         bklt_pkg::MODE_HOST: nxt_out_ff = brt_ff;
         default: nxt_out_ff = brt_ff;
      endcase
      nxt_duty_ff = lit ? out_ff : 8'h00;
   end

   // Sticky summary: a fault in the clearing cycle still sets it.
   always_comb begin
      nxt_fault_ff = (fault_ff && !fault_clr) || (|flags); // R11 R14
   end

   // Read path; reserved and unmapped bits return zero.
   always_comb begin
      nxt_rvalid_ff = reg_req.rd;
      nxt_rdata_ff = rdata_ff;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `BKLT_OFS_BRT: nxt_rdata_ff = (cur_mode == bklt_pkg::MODE_EXT) ? out_ff : brt_ff; // R8
            `BKLT_OFS_CTL: nxt_rdata_ff = {5'h00, ctl_ff}; // R3 R4 R5
            `BKLT_OFS_STAT: nxt_rdata_ff = {2'h0, flags.multi, flags.single, lit,
                                           flags.overcurrent, flags.thermal, fault_ff}; // R12
            `BKLT_OFS_ID: nxt_rdata_ff = {1'b1, VENDOR_ID, REVISION}; // R19 R20
            default: nxt_rdata_ff = 8'h00; // R23
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_ff <= `BKLT_RST_CTL; // R10
         brt_ff <= `BKLT_RST_BRT; // R22
         out_ff <= `BKLT_RST_BRT;
         duty_ff <= 8'h00;
         fault_ff <= 1'b0; // R18
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         ctl_ff <= nxt_ctl_ff;
         brt_ff <= nxt_brt_ff;
         out_ff <= nxt_out_ff;
         duty_ff <= nxt_duty_ff;
         fault_ff <= nxt_fault_ff;
         rdata_ff <= nxt_rdata_ff;
         rvalid_ff <= nxt_rvalid_ff;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign backlight_on = lit;
   assign dim_duty = duty_ff;

   // Checks kept beside the logic they guard.

   // A write that raises the enable bit from zero.
   sequence s_en_on_write;
      wr_ctl && reg_req.wdata[`BKLT_CTL_EN] && !ctl_ff[`BKLT_CTL_EN];
   endsequence

   // A write that drops the enable bit.
   sequence s_en_off_write;
      wr_ctl && !reg_req.wdata[`BKLT_CTL_EN];
   endsequence

   // Reads of the control, status and brightness registers.
   sequence s_ctl_read;
      reg_req.rd && reg_req.addr == `BKLT_OFS_CTL;
   endsequence

   sequence s_stat_read;
      reg_req.rd && reg_req.addr == `BKLT_OFS_STAT;
   endsequence

   sequence s_brt_read;
      reg_req.rd && reg_req.addr == `BKLT_OFS_BRT;
   endsequence

   // Cycles spent enabled but dark; a counter keeps long waits out of properties.
   logic [31:0] on_wait_ff;
   logic [31:0] nxt_on_wait_ff;

   always_comb begin
      nxt_on_wait_ff = 32'h0;
      if (ctl_ff[`BKLT_CTL_EN] && !lit) begin
         nxt_on_wait_ff = on_wait_ff + 32'h1;
      end
   end

   // The wait counter itself.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         on_wait_ff <= 32'h0;
      end else begin
         on_wait_ff <= nxt_on_wait_ff;
      end
   end

   // The turn-on wait never runs past the programmed delay.
   chk_on_delay_bound: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
      on_wait_ff <= ON_DELAY_CYC) else $error("Backlight did not light in time.");

   // A clearing write darkens the backlight at the next edge.
   chk_off_at_once: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
      s_en_off_write |=> !backlight_on)
      else $error("Backlight stayed on after disable.");

   // While dark the sinks see zero duty one cycle later.
   chk_duty_dark: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
      !backlight_on |=> dim_duty == 8'h00)
      else $error("Duty not zero while dark.");

   // An off write one or two cycles after the on write counts as immediate.
   chk_quick_toggle: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
      s_en_on_write ##[1:2] s_en_off_write |=> ##3 !fault_ff)
      else $error("Fault recorded on quick toggle.");

   // Once set the summary holds until a clear.
   chk_fault_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
      (fault_ff && !fault_clr) |=> fault_ff) else $error("Fault summary lost.");

   // A clear with no live flag leaves the summary low.
   chk_fault_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
      (fault_clr && !(|flags)) |=> !fault_ff) else $error("Fault summary not cleared.");

   // Any live flag sets the summary on the next edge.
   chk_fault_or: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
      (|flags) |=> fault_ff) else $error("Fault summary missed a flag.");

   // Two channels down always implies one channel down.
   chk_multi_nests: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
      flags.multi |-> flags.single) else $error("Multi flag without single flag.");

   // Control reads give the latched bits with zeros above.
   chk_ctl_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
      s_ctl_read |=>
      (reg_rvalid && reg_rdata == {5'h00, $past(ctl_ff)})) else $error("Control read wrong.");

   // Status reads show the lit state in bit 3 and zeros in the reserved bits.
   chk_stat_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12 R15
      s_stat_read |=> (reg_rdata[`BKLT_ST_ON] == $past(lit) && reg_rdata[7:6] == 2'h0))
      else $error("Status read wrong.");

   // Every read is answered one cycle later.
   chk_read_answer: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
      reg_req.rd |=> reg_rvalid) else $error("Read not answered.");

   // Brightness writes in external mode leave the register alone.
   chk_brt_guard: assert property (@(posedge sys_clk) disable iff (sys_rst) // R21
      (wr_brt && cur_mode == bklt_pkg::MODE_EXT && !wr_ctl) |=> $stable(brt_ff))
      else $error("Brightness changed outside host mode.");

   // External mode reads give the brightness in effect.
   chk_brt_read_ext: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
      (s_brt_read ##0 (cur_mode == bklt_pkg::MODE_EXT)) |=> reg_rdata == $past(out_ff))
      else $error("External brightness read wrong.");

   // Other modes read back the stored brightness.
   chk_brt_read_kept: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
      (s_brt_read ##0 (cur_mode != bklt_pkg::MODE_EXT)) |=> reg_rdata == $past(brt_ff))
      else $error("Stored brightness read wrong.");

   // External mode passes the measured duty straight through.
   chk_ext_follow: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
      (cur_mode == bklt_pkg::MODE_EXT) |=> out_ff == $past(meas))
      else $error("External mode output wrong.");

   // Host mode drives the stored brightness.
   chk_host_follow: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
      (cur_mode == bklt_pkg::MODE_HOST) |=> out_ff == $past(brt_ff))
      else $error("Host mode output wrong.");

   // Scaled mode at zero or full measured duty gives zero or the stored value.
   chk_scaled_ends: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
      (cur_mode == bklt_pkg::MODE_SCALED && (meas == 8'h00 || meas == 8'hff)) |=>
      out_ff == (($past(meas) == 8'h00) ? 8'h00 : $past(brt_ff)))
      else $error("Scaled output wrong.");

   // Entering host mode leaves the output where it was.
   chk_host_keep: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
      (wr_ctl && new_mode == bklt_pkg::MODE_HOST && cur_mode != bklt_pkg::MODE_HOST)
      |=> ##1 (out_ff == $past(out_ff, 2))) else $error("Host entry moved brightness.");

   // Reads outside the map return zero.
   chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // R23
      (reg_req.rd && reg_req.addr > `BKLT_OFS_ID) |=> reg_rdata == 8'h00)
      else $error("Unmapped read not zero.");

   // Writes outside the map change no register.
   chk_unmapped_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R23
      (reg_req.wr && reg_req.addr > `BKLT_OFS_ID) |=> ($stable(ctl_ff) && $stable(brt_ff)))
      else $error("Unmapped write changed a register.");

   // The identity byte always carries its top bit.
   chk_id_value: assert property (@(posedge sys_clk) disable iff (sys_rst) // R19
      (reg_req.rd && reg_req.addr == `BKLT_OFS_ID) |=> reg_rdata[`BKLT_ID_PANEL])
      else $error("Identity panel bit low.");

   // No flag is raised while the supply rail is missing.
   chk_supply_loss: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
      !pin_s2_ff[CHANNELS+2] |-> !(|flags)) else $error("Flag set without supply.");
endmodule

// [bklt_dim_source.sv]
// Model of the external dimming source that drives the dimming pin of the register bank.
// Assumes dim_clk comes from the bench; the bench picks the steady level of the pin.
`timescale 1ns/10ps
module bklt_dim_source (
   input wire logic dim_clk, // Clock of the dimming source.
   input wire logic level, // Wanted level of the pin.
   output logic ext_out // Dimming pin.
);
   // The pin starts low so the bank never samples an unknown level.
   initial ext_out = 1'b0;
   // The pin changes only on the source clock, as a real source would.
   always @(posedge dim_clk) begin
      ext_out <= level;
   end
endmodule

// [bklt_ctrl_regs_test.sv]
// Self-checking bench of the backlight control, status and identity registers.
// Assumes the byte request port of bklt_ctrl_regs and the dimming source model.
`timescale 1ns/10ps
`include "bklt_defines.svh"
`define CHK(got, exp, msg) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp); \
   end \
end
module bklt_ctrl_regs_test;
   // A short turn-on delay keeps the run brief; expectations derive from it.
   localparam int unsigned ON_CYC = 20;
   localparam logic [7:0] BRIGHTNESS_LEVEL = `BKLT_OFS_BRT;
   localparam logic [7:0] CTL = `BKLT_OFS_CTL;
   localparam logic [7:0] STAT = `BKLT_OFS_STAT;
   int bad_count = 0;
   int total_checks = 0;
   logic sys_clk = 1'b0;
   logic dim_clk = 1'b0;
   logic sys_rst = 1'b0;
   bklt_pkg::bklt_reg_req_t reg_req = '0;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic ext_pin;
   logic ext_level = 1'b0;
   logic thermal = 1'b0;
   logic ovc = 1'b0;
   logic [7:0] chan = 8'h00;
   logic supply = 1'b1;
   logic backlight_on;
   logic [7:0] dim_duty;
   // System clock at 125 MHz.
   always #4 sys_clk = ~sys_clk;
   // Link clock of 32 ns, offset so its edges never meet the system edges.
   initial begin
      #5;
      forever #16 dim_clk = ~dim_clk;
   end
   bklt_ctrl_regs #(.ON_DELAY_CYC(ON_CYC), .CHANNELS(8)) bklt_ctrl_regs_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .dim_clk(dim_clk), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .external_dimming_input(ext_pin),
      .thermal_fault_pin(thermal), .overcurrent_pin(ovc), .channel_fault_pin(chan),
      .backlight_supply_good(supply), .backlight_on(backlight_on), .dim_duty(dim_duty));
   bklt_dim_source bklt_dim_source_i (.dim_clk(dim_clk), .level(ext_level), .ext_out(ext_pin));
   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // One write pulse; the bank takes it at the edge where this task returns.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge sys_clk);
      reg_req <= '0;
   endtask
   // One read pulse; data and valid are looked at in the cycle they stand.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string m);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge sys_clk);
      reg_req <= '0;
      #1;
      `CHK(reg_rvalid, 1'b1, "read valid")
      `CHK(reg_rdata, e, m)
   endtask
   // Enables the backlight and waits a bounded time for it to light.
   task automatic light(input logic [7:0] c);
      int n;
      n = 0;
      wr(CTL, c);
      while (backlight_on !== 1'b1 && n < ON_CYC + 4) begin
         cyc(1);
         n++;
      end
      `CHK(backlight_on, 1'b1, "turn-on time")
   endtask
   task automatic t_reset;
      `CHK(backlight_on, 1'b0, "off after reset")
      `CHK(dim_duty, 8'h00, "duty after reset")
      rd_chk(CTL, 8'h00, "control reset");
      rd_chk(STAT, 8'h00, "status reset");
      rd_chk(BRIGHTNESS_LEVEL, 8'hff, "brightness reset");
      rd_chk(`BKLT_OFS_ID, 8'ha8, "identity");
      wr(`BKLT_OFS_ID, 8'h00);
      rd_chk(`BKLT_OFS_ID, 8'ha8, "identity read-only");
      wr(8'h07, 8'h5a);
      rd_chk(8'h07, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_ctl;
      wr(CTL, 8'hf8);
      rd_chk(CTL, 8'h00, "reserved control bits");
      cyc(ON_CYC + 4);
      `CHK(backlight_on, 1'b0, "reserved bits no effect")
      wr(CTL, 8'hfc);
      rd_chk(CTL, 8'h04, "latched control bits");
      wr(STAT, 8'hff);
      rd_chk(STAT, 8'h00, "status read-only");
      $display("test control done");
   endtask
   // Walks the three dimming modes with the external input high, then low.
   task automatic t_modes;
      wr(BRIGHTNESS_LEVEL, 8'h40);
      rd_chk(BRIGHTNESS_LEVEL, 8'h40, "brightness written");
      light(8'h05);
      cyc(2);
      `CHK(dim_duty, 8'h40, "host duty")
      rd_chk(STAT, 8'h08, "on flag");
      ext_level <= 1'b1;
      wr(CTL, 8'h07);
      wr(BRIGHTNESS_LEVEL, 8'h10);
      cyc(2200);
      `CHK(dim_duty, 8'hff, "external duty")
      rd_chk(BRIGHTNESS_LEVEL, 8'hff, "effective brightness");
      wr(CTL, 8'h01);
      cyc(2);
      `CHK(dim_duty, 8'h40, "scaled after ignored write")
      wr(CTL, 8'h07);
      cyc(2);
      `CHK(dim_duty, 8'hff, "external applied at once")
      wr(CTL, 8'h05);
      cyc(2);
      `CHK(dim_duty, 8'hff, "host entry keeps output")
      rd_chk(BRIGHTNESS_LEVEL, 8'hff, "host entry brightness");
      wr(BRIGHTNESS_LEVEL, 8'h40);
      wr(CTL, 8'h01);
      ext_level <= 1'b0;
      cyc(2200);
      `CHK(dim_duty, 8'h00, "scaled by zero duty")
      rd_chk(BRIGHTNESS_LEVEL, 8'h40, "scaled keeps written");
      // Back to host mode with a nonzero level so the off checks can trip.
      wr(CTL, 8'h05);
      wr(BRIGHTNESS_LEVEL, 8'h40);
      cyc(2);
      `CHK(dim_duty, 8'h40, "host duty before off")
      wr(CTL, 8'h00);
      cyc(1);
      `CHK(backlight_on, 1'b0, "off at once")
      cyc(1);
      `CHK(dim_duty, 8'h00, "duty off")
      rd_chk(STAT, 8'h00, "off flag");
      $display("test modes done");
   endtask
   // Fault flags, the sticky summary and its two ways of clearing.
   task automatic t_fault;
      light(8'h05);
      thermal <= 1'b1;
      cyc(5);
      rd_chk(STAT, 8'h0b, "thermal");
      thermal <= 1'b0;
      cyc(5);
      rd_chk(STAT, 8'h09, "sticky summary");
      wr(STAT, 8'hfe);
      rd_chk(STAT, 8'h08, "cleared by write");
      chan <= 8'h04;
      cyc(5);
      rd_chk(STAT, 8'h19, "one channel");
      chan <= 8'h84;
      cyc(5);
      rd_chk(STAT, 8'h39, "two channels");
      chan <= 8'h00;
      ovc <= 1'b1;
      cyc(5);
      rd_chk(STAT, 8'h0d, "overcurrent");
      ovc <= 1'b0;
      wr(CTL, 8'h04);
      wr(CTL, 8'h05);
      rd_chk(STAT, 8'h00, "cleared by toggle");
      cyc(ON_CYC + 4);
      supply <= 1'b0;
      thermal <= 1'b1;
      cyc(5);
      rd_chk(STAT, 8'h08, "supply loss");
      thermal <= 1'b0;
      cyc(5);
      supply <= 1'b1;
      wr(CTL, 8'h04);
      thermal <= 1'b1;
      wr(CTL, 8'h05);
      wr(CTL, 8'h04);
      cyc(5);
      rd_chk(STAT, 8'h00, "quick on and off");
      thermal <= 1'b0;
      $display("test fault done");
   endtask
   // Watchdog sized well above the expected run of about 4600 cycles.
   initial begin
      #400000;
      bad_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end
   // Reset for three cycles, then the scenarios in turn.
   initial begin
      sys_rst <= 1'b1; // A rising edge resets the link-clock side before its first edge.
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      cyc(2);
      t_reset();
      t_ctl();
      t_modes();
      t_fault();
      end_sim();
   end
endmodule
